// ===== hdl/occ_defs.svh
// register map, reset values and timing constants for clock control
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH
`define OCC_ADDR_IOSC     16'hFFA0
`define OCC_ADDR_CMODE    16'hFFA1
`define OCC_ADDR_MOSC     16'hFFA2
`define OCC_RST_IOSC      8'h00
`define OCC_RST_MOSC      8'h80
`define OCC_RST_CMODE     8'h00
`define OCC_RD_IDLE       8'h00
`define OCC_BIT_STABLE    7
`define OCC_BIT_LS_HALT   1
`define OCC_BIT_HS_HALT   0
`define OCC_BIT_MAIN_HALT 7
`define OCC_BIT_SYS_SEL   2
`define OCC_BIT_STATUS    1
`define OCC_BIT_SPLIT     0
`define OCC_SETTLE_NS     200
`define OCC_CLK_NS        50
`define OCC_SETTLE_CYC    ((`OCC_SETTLE_NS + `OCC_CLK_NS - 1) / `OCC_CLK_NS)
`endif

// ===== hdl/occ_pkg.sv
// types shared by the clock control block
package occ_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } occ_bus_t;

    typedef enum logic [1:0] {
        OCC_PIN_PORT = 2'h0,
        OCC_PIN_OSC  = 2'h1,
        OCC_PIN_EXT  = 2'h2
    } occ_pin_mode_t;

    typedef struct packed {
        logic main_hs;
        logic periph_hs;
    } occ_src_t;

    typedef enum logic [2:0] {
        OCC_SW_IDLE = 3'h1,
        OCC_SW_WAIT = 3'h2,
        OCC_SW_DONE = 3'h4
    } occ_sw_state_t;
endpackage : occ_pkg

// ===== hdl/occ_top.sv
// oscillator and main clock control logic
// How it works
// RULE1: sub pin mode from crystal-start bit and two sub mode bits.
// RULE2: internal osc mode reg reads 00H at reset, 80H once stable.
// RULE3: bit 7 reads 0 while high-speed osc settles, 1 when stable.
// RULE4: bit 1 at 1 halts low-speed oscillator, 0 runs it.
// RULE5: bit 0 at 1 halts high-speed oscillator, 0 runs it.
// RULE6: software halts high-speed osc only when cpu uses other clock.
// RULE7: main halt bit resets 1; 0 runs crystal or enables ext input.
// RULE8: software halts main osc only when cpu uses another clock.
// RULE9: software never clears main halt while pins are in port mode.
// RULE10: stopped peripherals need reinitialising before resuming.
// RULE11: select bit picks peripheral source, split bit picks main source.
// RULE12: status bit 1 reads 0 for internal, 1 for high-speed system.
// RULE13: system select bit may change only once after reset.
// RULE14: watchdog always runs from the low-speed oscillator.
// RULE15: 8-bit timer on low-speed rates uses the low-speed oscillator.
// RULE16: external-clock peripherals bypass peripheral clock, except 16-bit timers.
// RULE17: main clock mode register resets to 00H, internal source.
// RULE18: hs pin mode: port, crystal, or external input from two bits.
// RULE19: clock switches are glitch free; status follows completion.
`timescale 1ns/1ps
`include "occ_defs.svh"
module occ_top #(
    parameter int NPER = 4
) (
    // clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            rst_n_i,
    // register access
    input  occ_pkg::occ_bus_t    bus_i,
    output logic [7:0]           rdata_o,
    // bits held in neighbouring registers
    input  wire logic            hs_pin_mode_select_i,
    input  wire logic            ext_main_clock_input_i,
    input  wire logic            sub_crystal_start_i,
    input  wire logic            ext_sub_clock_select_i,
    input  wire logic            sub_pin_mode_select_i,
    input  wire logic            cpu_on_subclock_flag_i,
    // oscillator status
    input  wire logic            hs_osc_ready_i,
    input  wire logic            main_clk_ready_i,
    // peripheral source requests
    input  wire logic            timer8_ls_rate_i,
    input  wire logic [NPER-1:0] ext_src_sel_i,
    input  wire logic [NPER-1:0] timer16_edge_i,
    // oscillator controls
    output logic                 hs_osc_run_o,
    output logic                 ls_osc_run_o,
    output logic                 main_osc_run_o,
    output logic                 ext_clk_en_o,
    output occ_pkg::occ_pin_mode_t hs_pin_mode_o,
    output occ_pkg::occ_pin_mode_t sub_pin_mode_o,
    // clock routing
    output occ_pkg::occ_src_t    src_sel_o,
    output logic                 main_source_status_o,
    output logic                 wdt_ls_clk_o,
    output logic                 timer8_ls_clk_o,
    output logic [NPER-1:0]      periph_bypass_o
);
    localparam logic [7:0] SETTLE = 8'(`OCC_SETTLE_CYC);

    logic                  stable_q, stable_d;
    logic                  ls_halt_q, ls_halt_d;
    logic                  hs_halt_q, hs_halt_d;
    logic                  main_halt_q, main_halt_d;
    logic                  sys_sel_q, sys_sel_d;
    logic                  split_q, split_d;
    logic                  sel_lock_q, sel_lock_d;
    logic                  status_q, status_d;
    occ_pkg::occ_src_t     src_q, src_d, tgt;
    occ_pkg::occ_sw_state_t st_q, st_d;
    logic [7:0]            cnt_q, cnt_d;
    logic [7:0]            rdata_d;
    occ_pkg::occ_pin_mode_t hs_mode, sub_mode;
    logic                  tgt_ok;

    // pin modes
    always_comb
    begin
        if (!hs_pin_mode_select_i)
            hs_mode = occ_pkg::OCC_PIN_PORT; // see RULE18
        else if (ext_main_clock_input_i)
            hs_mode = occ_pkg::OCC_PIN_EXT; // see RULE18
        else
            hs_mode = occ_pkg::OCC_PIN_OSC; // see RULE18
        if (sub_crystal_start_i)
            sub_mode = occ_pkg::OCC_PIN_OSC; // see RULE1
        else if (!sub_pin_mode_select_i)
            sub_mode = occ_pkg::OCC_PIN_PORT; // see RULE1
        else if (ext_sub_clock_select_i)
            sub_mode = occ_pkg::OCC_PIN_EXT; // see RULE1
        else
            sub_mode = occ_pkg::OCC_PIN_OSC; // see RULE1
    end

    // registers
    always_comb
    begin
        stable_d    = hs_osc_ready_i & ~hs_halt_q; // see RULE2 RULE3
        ls_halt_d   = ls_halt_q;
        hs_halt_d   = hs_halt_q;
        main_halt_d = main_halt_q;
        sys_sel_d   = sys_sel_q;
        split_d     = split_q;
        sel_lock_d  = sel_lock_q;
        rdata_d     = `OCC_RD_IDLE;
        if (bus_i.wr)
        begin
            case (bus_i.addr)
                `OCC_ADDR_IOSC:
                begin
                    ls_halt_d = bus_i.wdata[`OCC_BIT_LS_HALT]; // see RULE4
                    hs_halt_d = bus_i.wdata[`OCC_BIT_HS_HALT]; // see RULE5
                end
                `OCC_ADDR_MOSC:
                    main_halt_d = bus_i.wdata[`OCC_BIT_MAIN_HALT]; // see RULE7
                `OCC_ADDR_CMODE:
                begin
                    split_d = bus_i.wdata[`OCC_BIT_SPLIT];
                    // one change allowed per reset
                    if (!sel_lock_q &&
                        bus_i.wdata[`OCC_BIT_SYS_SEL] != sys_sel_q)
                    begin
                        sys_sel_d  = bus_i.wdata[`OCC_BIT_SYS_SEL]; // see RULE13
                        sel_lock_d = 1'b1; // see RULE13
                    end
                end
                default:
                    ;
            endcase
        end
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                `OCC_ADDR_IOSC:
                    rdata_d = {stable_q, 5'h00, ls_halt_q, hs_halt_q}; // see RULE2
                `OCC_ADDR_MOSC:
                    rdata_d = {main_halt_q, 7'h00};
                `OCC_ADDR_CMODE:
                    rdata_d = {5'h00, sys_sel_q, status_q, split_q}; // see RULE12
                default:
                    rdata_d = `OCC_RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stable_q    <= 1'(`OCC_RST_IOSC >> `OCC_BIT_STABLE); // see RULE2
            ls_halt_q   <= 1'b0;
            hs_halt_q   <= 1'b0;
            main_halt_q <= 1'(`OCC_RST_MOSC >> `OCC_BIT_MAIN_HALT); // see RULE7
            sys_sel_q   <= 1'b0; // see RULE17
            split_q     <= 1'b0; // see RULE17
            sel_lock_q  <= 1'b0;
            rdata_o     <= `OCC_RD_IDLE;
        end
        else
        begin
            stable_q    <= stable_d;
            ls_halt_q   <= ls_halt_d;
            hs_halt_q   <= hs_halt_d;
            main_halt_q <= main_halt_d;
            sys_sel_q   <= sys_sel_d;
            split_q     <= split_d;
            sel_lock_q  <= sel_lock_d;
            rdata_o     <= rdata_d;
        end
    end

    // source switch: a new source is taken only when it is running,
    // and after a settle gap so neither clock is cut short
    always_comb
    begin
        tgt.periph_hs = sys_sel_q; // see RULE11
        tgt.main_hs   = sys_sel_q & split_q; // see RULE11
        // high-speed system clock is only usable when enabled and alive
        tgt_ok = (!(tgt.main_hs | tgt.periph_hs) ||
                  (!main_halt_q && hs_mode != occ_pkg::OCC_PIN_PORT &&
                   main_clk_ready_i)) &&
                 (!(~tgt.main_hs | ~tgt.periph_hs) || !hs_halt_q);
        st_d     = st_q;
        cnt_d    = cnt_q;
        src_d    = src_q;
        status_d = status_q;
        case (st_q)
            occ_pkg::OCC_SW_IDLE:
                if (tgt != src_q && tgt_ok)
                begin
                    st_d  = occ_pkg::OCC_SW_WAIT;
                    cnt_d = SETTLE;
                end
            occ_pkg::OCC_SW_WAIT:
                if (cnt_q == 8'h01)
                begin
                    src_d = tgt; // see RULE19
                    st_d  = occ_pkg::OCC_SW_DONE;
                end
                else
                    cnt_d = cnt_q - 8'h01;
            occ_pkg::OCC_SW_DONE:
            begin
                status_d = src_q.main_hs; // see RULE19 RULE12
                st_d     = occ_pkg::OCC_SW_IDLE;
            end
            default:
                st_d = occ_pkg::OCC_SW_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q     <= occ_pkg::OCC_SW_IDLE;
            cnt_q    <= 8'h00;
            src_q    <= '0; // see RULE17
            status_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            src_q    <= src_d;
            status_q <= status_d;
        end
    end

    // registered outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hs_osc_run_o         <= 1'b1;
            ls_osc_run_o         <= 1'b1;
            main_osc_run_o       <= 1'b0;
            ext_clk_en_o         <= 1'b0;
            hs_pin_mode_o        <= occ_pkg::OCC_PIN_PORT;
            sub_pin_mode_o       <= occ_pkg::OCC_PIN_PORT;
            src_sel_o            <= '0;
            main_source_status_o <= 1'b0;
            wdt_ls_clk_o         <= 1'b1;
            timer8_ls_clk_o      <= 1'b0;
            periph_bypass_o      <= '0;
        end
        else
        begin
            hs_osc_run_o    <= ~hs_halt_q; // see RULE5
            ls_osc_run_o    <= ~ls_halt_q; // see RULE4
            main_osc_run_o  <= ~main_halt_q &
                               (hs_mode == occ_pkg::OCC_PIN_OSC); // see RULE7
            ext_clk_en_o    <= ~main_halt_q &
                               (hs_mode == occ_pkg::OCC_PIN_EXT); // see RULE7
            hs_pin_mode_o   <= hs_mode; // see RULE18
            sub_pin_mode_o  <= sub_mode; // see RULE1
            src_sel_o       <= src_q; // see RULE11
            main_source_status_o <= status_q; // see RULE12
            // watchdog never follows the peripheral clock choice
            wdt_ls_clk_o    <= 1'b1; // see RULE14
            timer8_ls_clk_o <= timer8_ls_rate_i; // see RULE15
            periph_bypass_o <= ext_src_sel_i & ~timer16_edge_i; // see RULE16
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_stable_read: assert property (bus_i.rd &&
        bus_i.addr == `OCC_ADDR_IOSC |=> rdata_o[7] == $past(stable_q))
        else $error("stability bit read mismatch"); // see RULE3
    a_stable_follow: assert property (hs_osc_ready_i && !hs_halt_q
        |=> stable_q) else $error("stable flag not set"); // see RULE2
    a_ls_halt_out: assert property (ls_halt_q |=> !ls_osc_run_o)
        else $error("low-speed osc not halted"); // see RULE4
    a_hs_halt_out: assert property (hs_halt_q |=> !hs_osc_run_o)
        else $error("high-speed osc not halted"); // see RULE5
    a_main_halt_out: assert property (main_halt_q
        |=> !main_osc_run_o && !ext_clk_en_o)
        else $error("main osc running while halted"); // see RULE7
    a_sel_once: assert property (sel_lock_q |=> $stable(sys_sel_q))
        else $error("system select changed twice"); // see RULE13
    a_status_lag: assert property ($changed(src_q.main_hs)
        |=> status_q == src_q.main_hs)
        else $error("status did not follow switch"); // see RULE19
    a_src_settle: assert property ($changed(src_q)
        |-> $past(st_q, 1) == occ_pkg::OCC_SW_WAIT)
        else $error("source changed without settle"); // see RULE19
    a_periph_map: assert property (src_q.main_hs |-> src_q.periph_hs)
        else $error("main on hs while periph internal"); // see RULE11
    a_bypass_tm16: assert property (timer16_edge_i[0]
        |=> !periph_bypass_o[0])
        else $error("16-bit timer bypassed"); // see RULE16
    a_wdt_ls: assert property (wdt_ls_clk_o)
        else $error("watchdog left low-speed clock"); // see RULE14
endmodule : occ_top

// ===== testbench/tb_top.sv
// self-checking bench for the oscillator and main clock control block
`timescale 1ns/1ps
`include "occ_defs.svh"
module tb_top;
    // pins: hs sel, hs ext, crystal start, sub ext, sub sel
    typedef struct packed {
        logic [4:0] pins;
        logic [3:0] esel;
        logic [3:0] tm16;
        logic [1:0] hs_exp;
        logic [1:0] sub_exp;
        logic [3:0] byp_exp;
    } occ_tb_row_t;

    logic                   clk;
    logic                   rst_n;
    occ_pkg::occ_bus_t      bus;
    logic [7:0]             rdata;
    logic [4:0]             pins;
    logic                   hs_rdy;
    logic                   mc_rdy;
    logic                   tm8;
    logic                   cpu_on_subclock_flag;
    logic [3:0]             esel;
    logic [3:0]             tm16;
    logic                   hs_run;
    logic                   ls_run;
    logic                   mo_run;
    logic                   ext_en;
    occ_pkg::occ_pin_mode_t hs_mode;
    occ_pkg::occ_pin_mode_t sub_mode;
    occ_pkg::occ_src_t      src;
    logic                   status;
    logic                   wdt;
    logic                   t8clk;
    logic [3:0]             byp;
    int                     miscompares;
    int                     checked;
    occ_tb_row_t            rows [6] = '{
        '{5'h00, 4'hF, 4'h5, 2'h0, 2'h0, 4'hA},
        '{5'h08, 4'h3, 4'h0, 2'h0, 2'h0, 4'h3},
        '{5'h11, 4'h0, 4'hF, 2'h1, 2'h1, 4'h0},
        '{5'h1B, 4'hC, 4'h8, 2'h2, 2'h2, 4'h4},
        '{5'h14, 4'h1, 4'h1, 2'h1, 2'h1, 4'h0},
        '{5'h07, 4'h2, 4'h4, 2'h0, 2'h1, 4'h2}};

    occ_top #(.NPER(4)) dut (
        .ref_clk_i              (clk),
        .rst_n_i                (rst_n),
        .bus_i                  (bus),
        .rdata_o                (rdata),
        .hs_pin_mode_select_i   (pins[4]),
        .ext_main_clock_input_i (pins[3]),
        .sub_crystal_start_i    (pins[2]),
        .ext_sub_clock_select_i (pins[1]),
        .sub_pin_mode_select_i  (pins[0]),
        .cpu_on_subclock_flag_i (cpu_on_subclock_flag),
        .hs_osc_ready_i         (hs_rdy),
        .main_clk_ready_i       (mc_rdy),
        .timer8_ls_rate_i       (tm8),
        .ext_src_sel_i          (esel),
        .timer16_edge_i         (tm16),
        .hs_osc_run_o           (hs_run),
        .ls_osc_run_o           (ls_run),
        .main_osc_run_o         (mo_run),
        .ext_clk_en_o           (ext_en),
        .hs_pin_mode_o          (hs_mode),
        .sub_pin_mode_o         (sub_mode),
        .src_sel_o              (src),
        .main_source_status_o   (status),
        .wdt_ls_clk_o           (wdt),
        .timer8_ls_clk_o        (t8clk),
        .periph_bypass_o        (byp)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // idle cycle after each access so back-to-back calls never
    // drive the bus twice in one time step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus = '{a, d, 1'b1, 1'b0};
        tick(1);
        bus = '0;
        tick(1);
    endtask : wr

    // read data is registered, so it is looked at in the following cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] e,
                      input string nm);
        bus = '{a, 8'h00, 1'b0, 1'b1};
        tick(1);
        bus = '0;
        chk(nm, rdata, e);
        tick(1);
    endtask : rd

    // bounded: the switch settles in a handful of cycles
    task automatic wait_status(input logic v);
        int n;
        n = 0;
        while (status !== v && n < 40)
        begin
            tick(1);
            n++;
        end
    endtask : wait_status

    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        #(50 * 3000);
        miscompares++;
        give_verdict();
    end

    initial
    begin
        bus = '0;
        pins = '0;
        hs_rdy = 1'b0;
        mc_rdy = 1'b0;
        tm8 = 1'b0;
        esel = '0;
        tm16 = '0;
        cpu_on_subclock_flag = 1'b0;
        rst_n = 1'b0;
        miscompares = 0;
        checked = 0;
        tick(20);
        chk("hs run", hs_run, 1'b1);
        chk("ls run", ls_run, 1'b1);
        chk("main run", mo_run, 1'b0);
        chk("src", src, 2'h0);
        rst_n = 1'b1;
        tick(1);
        rd(`OCC_ADDR_IOSC, 8'h00, "osc mode");
        rd(`OCC_ADDR_MOSC, 8'h80, "main osc");
        rd(`OCC_ADDR_CMODE, 8'h00, "clk mode");
        rd(16'hFFA5, 8'h00, "unmapped");
        chk("wdt", wdt, 1'b1);
        hs_rdy = 1'b1;
        tick(2);
        rd(`OCC_ADDR_IOSC, 8'h80, "osc mode stable");
        for (int i = 0; i < 6; i++)
        begin
            pins = rows[i].pins;
            esel = rows[i].esel;
            tm16 = rows[i].tm16;
            tm8 = i[0];
            tick(2);
            chk("hs mode", hs_mode, rows[i].hs_exp);
            chk("sub mode", sub_mode, rows[i].sub_exp);
            chk("bypass", byp, rows[i].byp_exp);
            chk("t8 clk", t8clk, i[0]);
            chk("main run", mo_run, 1'b0);
        end
        // cpu parked on the sub clock while the internal osc is off,
        // both ls and hs run outputs drop until it is restarted
        cpu_on_subclock_flag = 1'b1;
        wr(`OCC_ADDR_IOSC, 8'h03);
        tick(2);
        chk("ls run", ls_run, 1'b0);
        chk("hs run", hs_run, 1'b0);
        wr(`OCC_ADDR_IOSC, 8'h00);
        tick(2);
        chk("hs run", hs_run, 1'b1);
        cpu_on_subclock_flag = 1'b0;
        // pin mode only changes while the main oscillator is halted
        pins = 5'h10;
        tick(1);
        wr(`OCC_ADDR_MOSC, 8'h00);
        tick(2);
        chk("main run", mo_run, 1'b1);
        chk("ext en", ext_en, 1'b0);
        mc_rdy = 1'b1;
        wr(`OCC_ADDR_CMODE, 8'h05);
        chk("early status", status, 1'b0);
        wait_status(1'b1);
        chk("status", status, 1'b1);
        chk("src", src, 2'h3);
        rd(`OCC_ADDR_CMODE, 8'h07, "clk mode hs");
        wr(`OCC_ADDR_CMODE, 8'h00);
        wait_status(1'b0);
        chk("src", src, 2'h1);
        rd(`OCC_ADDR_CMODE, 8'h04, "clk mode lock");
        // main clock is back on the internal osc before this halt
        wr(`OCC_ADDR_MOSC, 8'h80);
        pins = 5'h18;
        tick(1);
        wr(`OCC_ADDR_MOSC, 8'h00);
        tick(2);
        chk("ext en", ext_en, 1'b1);
        chk("main run", mo_run, 1'b0);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
        rd(`OCC_ADDR_CMODE, 8'h00, "clk mode rst");
        wr(`OCC_ADDR_MOSC, 8'h00);
        wr(`OCC_ADDR_CMODE, 8'h04);
        tick(12);
        chk("src", src, 2'h1);
        chk("status", status, 1'b0);
        give_verdict();
    end
endmodule : tb_top
